// *** include/pot_pkg.sv ***
// Constants and types shared by the dual potentiometer command front end.
// Assumes a 20 MHz system clock and an AHB-Lite register bus of 32-bit words.
package pot_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 20;
	localparam int T_PROG_US    = 15000;
	localparam int T_RESTORE_US = 30;
	localparam int PROG_CYC     = T_PROG_US * CLK_MHZ;
	localparam int RESTORE_CYC  = T_RESTORE_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Values, command codes, field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] NV_RESET       = 8'h80;
	localparam logic [3:0] CMD_WR_WIPER   = 4'h1;
	localparam logic [3:0] CMD_WR_INPUT   = 4'h2;
	localparam logic [3:0] CMD_READBACK   = 4'h3;
	localparam logic [3:0] CMD_TRANSFER   = 4'h6;
	localparam logic [3:0] CMD_COPY       = 4'h7;
	localparam logic [3:0] CMD_WR_NV      = 4'h8;
	localparam logic [3:0] CMD_SOFT_RESET = 4'hB;
	localparam logic [3:0] CMD_SHUTDOWN   = 4'hC;
	localparam logic [1:0] RB_INPUT       = 2'h0;
	localparam logic [1:0] RB_NV          = 2'h1;
	localparam logic [1:0] RB_WIPER       = 2'h3;
	localparam logic [2:0] SLAVE_TOP      = 3'h2;
	localparam logic [1:0] PIN_LOW        = 2'h0;
	localparam logic [1:0] PIN_HIGH       = 2'h1;
	localparam logic [1:0] PIN_OPEN       = 2'h2;
	localparam int         CMD_MSB        = 15;
	localparam int         CMD_LSB        = 12;
	localparam int         ALL_CH_BIT     = 11;
	localparam int         CH_SEL_BIT     = 8;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_NV     = 8'h08;
	localparam logic [7:0]  REG_SLAVE  = 8'h0C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ACK_ADDR = 3'b011,
		ST_RX       = 3'b010,
		ST_ACK_RX   = 3'b110,
		ST_TX       = 3'b111,
		ST_ACK_TX   = 3'b101
	} i2c_state_t;

endpackage

// *** rtl/pot_i2c_cmd.sv ***
// I2C command decoder of a dual digital potentiometer, with AHB-Lite status/control.
// Assumes SCL, SDA, the address straps and the reset pin are asynchronous to hclk,
// and that a pad outside resolves the open-drain SDA from sda_oe_n.
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns

module pot_i2c_cmd
	import pot_pkg::*;
#(
	parameter int   PROG_CYCLES = PROG_CYC,
	parameter bit   RES_7BIT    = 1'b0,
	parameter int   CHANNELS    = 2
) (
	input  wire logic        hclk,                // System clock.
	input  wire logic        hresetn,             // Asynchronous reset, active low.
	input  wire logic        hsel,                // AHB slave select.
	input  wire logic [31:0] haddr,               // AHB address.
	input  wire logic [1:0]  htrans,              // AHB transfer type.
	input  wire logic        hwrite,              // AHB write.
	input  wire logic [2:0]  hsize,               // AHB size, word only.
	input  wire logic [31:0] hwdata,              // AHB write data.
	input  wire logic        hready,              // AHB bus ready.
	output logic      [31:0] hrdata,              // AHB read data.
	output logic             hreadyout,           // AHB slave ready.
	output logic             hresp,               // AHB response, always OKAY.
	input  wire logic        scl_in,              // I2C clock pin.
	input  wire logic        sda_in,              // I2C data pin level.
	output logic             sda_out,             // I2C data drive value, always low.
	output logic             sda_oe_n,            // Low while pulling SDA low.
	input  wire logic [1:0]  slave_addr_pin_low,  // Low strap: 0 low, 1 high, 2 open.
	input  wire logic [1:0]  slave_addr_pin_high, // High strap: 0 low, 1 high, 2 open.
	input  wire logic        pot_reset_n,         // Reload pin, active low.
	output logic      [7:0]  wiper_tap_ch1,       // Wiper tap of channel one.
	output logic      [7:0]  wiper_tap_ch2,       // Wiper tap of channel two.
	output logic      [1:0]  shutdown_ch,         // Per channel shutdown.
	output logic             nvm_busy             // Memory programming in progress.
);

	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int RW = $clog2(RESTORE_CYC + 1);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [1:0] pin_code(input logic [1:0] lvl, input logic open_ok);
		pin_code = (lvl == PIN_LOW) ? 2'b11 : ((lvl == PIN_OPEN) && open_ok) ? 2'b10 : 2'b00;
	endfunction

	function automatic logic [7:0] lsb_mask(input logic [7:0] d);
		lsb_mask = RES_7BIT ? {d[7:1], 1'b0} : d;
	endfunction

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic       scl_m_r, scl_r, scl_d_r;
	logic       sda_m_r, sda_r, sda_d_r;
	logic       rst_m_r, rst_pin_r;
	logic [1:0] strap_lo_m_r, strap_lo_r;
	logic [1:0] strap_hi_m_r, strap_hi_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{scl_m_r, scl_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_r, sda_d_r} <= 3'h7;
			{rst_m_r, rst_pin_r}      <= 2'h3;
			{strap_lo_m_r, strap_lo_r} <= {PIN_HIGH, PIN_HIGH};
			{strap_hi_m_r, strap_hi_r} <= {PIN_HIGH, PIN_HIGH};
		end else begin
			{scl_m_r, scl_r, scl_d_r} <= {scl_in, scl_m_r, scl_r};
			{sda_m_r, sda_r, sda_d_r} <= {sda_in, sda_m_r, sda_r};
			{rst_m_r, rst_pin_r}      <= {pot_reset_n, rst_m_r};
			{strap_lo_m_r, strap_lo_r} <= {slave_addr_pin_low, strap_lo_m_r};
			{strap_hi_m_r, strap_hi_r} <= {slave_addr_pin_high, strap_hi_m_r};
		end
	end

	// SDA edges count only while SCL stays high over both samples.
	wire scl_rise  = scl_r & ~scl_d_r;
	wire scl_fall  = ~scl_r & scl_d_r;
	wire start_det = scl_r & scl_d_r & sda_d_r & ~sda_r;
	wire stop_det  = scl_r & scl_d_r & ~sda_d_r & sda_r;

	// ----------------------------------------------------------------
	// Slave address and command fields
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r;
	wire         open_ok = ~ctrl_r[0];
	wire  [6:0]  slave_addr = {SLAVE_TOP, pin_code(strap_hi_r, open_ok), pin_code(strap_lo_r, open_ok)};

	logic [15:0] word_r;
	logic        exec_r;
	wire  [3:0]  cmd_code = word_r[CMD_MSB:CMD_LSB];
	wire  [7:0]  cmd_data = word_r[7:0];
	wire         cmd_ch   = word_r[CH_SEL_BIT] | word_r[CH_SEL_BIT+1];
	wire  [1:0]  ch_mask  = word_r[ALL_CH_BIT] ? 2'b11 : (cmd_ch ? 2'b10 : 2'b01);

	// ----------------------------------------------------------------
	// Memory programming lock and restore sequencing
	// ----------------------------------------------------------------
	logic [PW-1:0] prog_cnt_r;
	logic          busy_r;
	logic [RW-1:0] rest_cnt_r;
	logic          rest_act_r;

	wire prog_start = exec_r & ((cmd_code == CMD_WR_NV) | ((cmd_code == CMD_COPY) & cmd_data[0]));
	wire soft_rst   = exec_r & (cmd_code == CMD_SOFT_RESET);
	// Holding the pin low keeps the count at zero, so the reload lands after release.
	wire rest_done  = rest_act_r & rst_pin_r & (rest_cnt_r == RW'(RESTORE_CYC - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_cnt_r <= '0;
			busy_r     <= 1'b0;
		end else if (prog_start) begin
			prog_cnt_r <= PW'(PROG_CYCLES - 1);
			busy_r     <= 1'b1;
		end else if (busy_r) begin
			prog_cnt_r <= prog_cnt_r - 1'b1;
			busy_r     <= (prog_cnt_r != '0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rest_cnt_r <= '0;
			rest_act_r <= 1'b1;
		end else if (!rst_pin_r || soft_rst) begin
			rest_cnt_r <= '0;
			rest_act_r <= 1'b1;
		end else if (rest_done) begin
			rest_act_r <= 1'b0;
		end else if (rest_act_r) begin
			rest_cnt_r <= rest_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per channel wiper, input and memory registers
	// ----------------------------------------------------------------
	logic [7:0] wiper_r [CHANNELS];
	logic [7:0] input_r [CHANNELS];
	logic [7:0] nv_r    [CHANNELS];
	logic [1:0] sd_r;

	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				wiper_r[i] <= NV_RESET;
				input_r[i] <= NV_RESET;
				nv_r[i]    <= NV_RESET;
				sd_r[i]    <= 1'b0;
			end else if (rest_done) begin
				wiper_r[i] <= nv_r[i];
				input_r[i] <= nv_r[i];
			end else if (exec_r && ch_mask[i]) begin
				case (cmd_code)
					CMD_WR_WIPER: begin
						wiper_r[i] <= lsb_mask(cmd_data);
						input_r[i] <= lsb_mask(cmd_data);
					end
					CMD_WR_INPUT: begin
						input_r[i] <= lsb_mask(cmd_data);
					end
					CMD_TRANSFER: begin
						wiper_r[i] <= input_r[i];
					end
					CMD_COPY: begin
						if (cmd_data[0]) begin
							nv_r[i] <= wiper_r[i];
						end else begin
							wiper_r[i] <= nv_r[i];
							input_r[i] <= nv_r[i];
						end
					end
					CMD_WR_NV: begin
						nv_r[i] <= lsb_mask(cmd_data);
					end
					CMD_SHUTDOWN: begin
						sd_r[i] <= cmd_data[0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Readback selection
	// ----------------------------------------------------------------
	logic       rb_ch_r;
	logic [1:0] rb_sel_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rb_ch_r  <= 1'b0;
			rb_sel_r <= RB_WIPER;
		end else if (exec_r && cmd_code == CMD_READBACK) begin
			rb_ch_r  <= cmd_ch;
			rb_sel_r <= cmd_data[1:0];
		end
	end

	wire [7:0] rb_raw  = (rb_sel_r == RB_NV)    ? nv_r[rb_ch_r] :
	                     (rb_sel_r == RB_WIPER) ? wiper_r[rb_ch_r] :
	                     (rb_sel_r == RB_INPUT) ? input_r[rb_ch_r] : 8'h00;
	wire [7:0] rb_byte = lsb_mask(rb_raw);

	// ----------------------------------------------------------------
	// I2C slave
	// ----------------------------------------------------------------
	i2c_state_t st_r;
	logic [7:0] shift_r;
	logic [7:0] hi_byte_r;
	logic [3:0] cnt_r;
	logic       rw_r;
	logic       first_r;
	logic       oe_n_r;

	// A 10-bit header or general call never equals a strap address, so both go unanswered.
	wire addr_hit = (shift_r[7:1] == slave_addr) & ~busy_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r      <= ST_IDLE;
			shift_r   <= 8'h00;
			hi_byte_r <= 8'h00;
			cnt_r     <= 4'h0;
			rw_r      <= 1'b0;
			first_r   <= 1'b1;
			oe_n_r    <= 1'b1;
			exec_r    <= 1'b0;
			word_r    <= 16'h0000;
		end else begin
			exec_r <= 1'b0;
			if (start_det) begin
				st_r    <= ST_ADDR;
				cnt_r   <= 4'h0;
				first_r <= 1'b1;
				oe_n_r  <= 1'b1;
			end else if (stop_det) begin
				st_r   <= ST_IDLE;
				oe_n_r <= 1'b1;
			end else begin
				case (st_r)
					ST_ADDR, ST_RX: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_r};
							cnt_r   <= cnt_r + 1'b1;
						end else if (scl_fall && cnt_r == 4'h8) begin
							if (st_r == ST_ADDR) begin
								rw_r   <= shift_r[0];
								oe_n_r <= ~addr_hit;
								st_r   <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
							end else if (busy_r) begin
								st_r <= ST_IDLE;
							end else begin
								oe_n_r  <= 1'b0;
								st_r    <= ST_ACK_RX;
								first_r <= ~first_r;
								if (first_r) begin
									hi_byte_r <= shift_r;
								end else begin
									word_r <= {hi_byte_r, shift_r};
									exec_r <= 1'b1;
								end
							end
						end
					end
					ST_ACK_ADDR: begin
						if (scl_fall) begin
							cnt_r <= rw_r ? 4'h1 : 4'h0;
							if (rw_r) begin
								shift_r <= rb_byte;
								oe_n_r  <= rb_byte[7];
								st_r    <= ST_TX;
							end else begin
								oe_n_r <= 1'b1;
								st_r   <= ST_RX;
							end
						end
					end
					ST_ACK_RX: begin
						if (scl_fall) begin
							oe_n_r <= 1'b1;
							cnt_r  <= 4'h0;
							st_r   <= ST_RX;
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (cnt_r == 4'h8) begin
								oe_n_r <= 1'b1;
								st_r   <= ST_ACK_TX;
							end else begin
								oe_n_r  <= shift_r[6];
								shift_r <= {shift_r[6:0], 1'b0};
								cnt_r   <= cnt_r + 1'b1;
							end
						end
					end
					ST_ACK_TX: begin
						if (scl_rise && sda_r) begin
							st_r <= ST_IDLE;
						end else if (scl_fall) begin
							shift_r <= rb_byte;
							oe_n_r  <= rb_byte[7];
							cnt_r   <= 4'h1;
							st_r    <= ST_TX;
						end
					end
					default: begin
						oe_n_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic        wr_pend_r;
	logic [31:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic        hreadyout_r;
	logic        hresp_r;

	wire        take    = hsel & hready & htrans[1];
	wire [31:0] st_word = {12'h000, rest_act_r, sd_r[1], sd_r[0], busy_r, wiper_r[1], wiper_r[0]};
	wire [31:0] rd_word = (haddr == 32'(REG_CTRL))   ? ctrl_r :
	                      (haddr == 32'(REG_STATUS)) ? st_word :
	                      (haddr == 32'(REG_NV))     ? {16'h0000, nv_r[1], nv_r[0]} :
	                      (haddr == 32'(REG_SLAVE))  ? {25'h0000000, slave_addr} : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 32'h0000_0000;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			wr_pend_r   <= take & hwrite;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			if (take) begin
				wr_addr_r <= haddr;
			end
			if (take && !hwrite) begin
				hrdata_r <= rd_word;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_pend_r && wr_addr_r == 32'(REG_CTRL)) begin
			ctrl_r <= {31'h00000000, hwdata[0]};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic sda_out_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	assign hrdata        = hrdata_r;
	assign hreadyout     = hreadyout_r;
	assign hresp         = hresp_r;
	assign sda_out       = sda_out_r;
	assign sda_oe_n      = oe_n_r;
	assign wiper_tap_ch1 = wiper_r[0];
	assign wiper_tap_ch2 = wiper_r[1];
	assign shutdown_ch   = sd_r;
	assign nvm_busy      = busy_r;

endmodule

// *** verification/pot_i2c_cmd_asserts.sv ***
// Pin-level checks of the potentiometer command decoder.
// Assumes it is bound into pot_i2c_cmd and that everything runs on hclk.
`timescale 1ns/1ns
module pot_i2c_cmd_asserts
	import pot_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC
) (
	input wire logic       hclk,          // System clock.
	input wire logic       hresetn,       // Reset, active low.
	input wire logic       scl_in,        // Bus clock pin.
	input wire logic       sda_out,       // Data drive value.
	input wire logic       sda_oe_n,      // Data drive enable, active low.
	input wire logic [7:0] wiper_tap_ch1, // Channel one wiper.
	input wire logic [7:0] wiper_tap_ch2, // Channel two wiper.
	input wire logic [1:0] shutdown_ch,   // Shutdown levels.
	input wire logic       nvm_busy       // Programming lock.
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	int busy_cnt;

	// The lock is far too long to unroll, so its length is counted here.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_cnt <= 0;
		end else if (!nvm_busy) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	busy_time_a: assert property ($fell(nvm_busy) |-> busy_cnt >= PROG_CYCLES - 2 && busy_cnt <= PROG_CYCLES + 2)
		else $error("lock length wrong");
	busy_nack_a: assert property (nvm_busy && $past(nvm_busy, 12) |-> sda_oe_n)
		else $error("acknowledge while locked");
	sda_scl_low_a: assert property ($changed(sda_oe_n) |-> !$past(scl_in, 2))
		else $error("data moved while clock high");
	ack_pull_a: assert property (!sda_oe_n |-> sda_out == 1'b0)
		else $error("data driven high");
	ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
		else $error("acknowledge too short");
	shut_exec_a: assert property ($changed(shutdown_ch) |-> !$past(sda_oe_n))
		else $error("shutdown changed outside a command");
	busy_exec_a: assert property ($rose(nvm_busy) |-> !$past(sda_oe_n))
		else $error("lock started outside a command");
	reset_mid_a: assert property ($rose(hresetn) |-> (wiper_tap_ch1 == NV_RESET && wiper_tap_ch2 == NV_RESET
		&& shutdown_ch == 2'h0) ##1 $stable(wiper_tap_ch1) [*8])
		else $error("wiper not at half scale after reset");

	cover property ($rose(nvm_busy));
	cover property ($fell(sda_oe_n));
	cover property ($changed(shutdown_ch));
endmodule

bind pot_i2c_cmd pot_i2c_cmd_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (.hclk(hclk), .hresetn(hresetn),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wiper_tap_ch1(wiper_tap_ch1),
	.wiper_tap_ch2(wiper_tap_ch2), .shutdown_ch(shutdown_ch), .nvm_busy(nvm_busy));

// *** verification/i2c_master_model.sv ***
// Behavioural I2C bus master for the decoder's serial pins.
// Assumes a pull-up resolves SDA from every open-drain driver.
`timescale 1ns/1ns
module i2c_master_model (
	output logic     scl,     // Bus clock, stands high between frames.
	output logic     sda_drv, // Open-drain data, 0 pulls low.
	input wire logic sda      // Resolved data wire.
);
	// ----------------------------------------------------------------
	// Bus cycles, 400 ns clock period
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// Data moves mid low phase and is sampled mid high phase.
	task automatic clk_bit(input logic b, output logic r);
		#100 sda_drv = b;
		#100 scl = 1'b1;
		#100 r = sda;
		#100 scl = 1'b0;
	endtask

	task automatic start;
		#13 sda_drv = 1'b1;
		#100 scl = 1'b1;
		#200 sda_drv = 1'b0;
		#200 scl = 1'b0;
	endtask

	task automatic stop;
		#100 sda_drv = 1'b0;
		#100 scl = 1'b1;
		#200 sda_drv = 1'b1;
		#200;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(last, r);
	endtask
endmodule

// *** verification/test_dual_pot_i2c_command_decoder.sv ***
// Self-checking bench for the potentiometer command decoder.
// Assumes the I2C master model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin err_count++; $display("Error at %0t: got %0h expected %0h", $time, x, y); end end
module test_dual_pot_i2c_command_decoder
	import pot_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, pot_reset_n, hreadyout, hresp;
	logic        scl, sda_drv, sda_out, sda_oe_n, sda_oe_n7, nvm_busy, a;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, pin_lo, pin_hi, shutdown_ch;
	logic [7:0]  w1, w2, w7, b;
	logic [6:0]  dev;
	int          err_count, checks_done;
	wire         sda = sda_drv & sda_oe_n & sda_oe_n7;
	logic [10:0] straps [9] = '{{2'h1, 2'h1, 7'h20}, {2'h2, 2'h1, 7'h22}, {2'h0, 2'h1, 7'h23},
		{2'h1, 2'h2, 7'h28}, {2'h2, 2'h2, 7'h2A}, {2'h0, 2'h2, 7'h2B}, {2'h1, 2'h0, 7'h2C},
		{2'h2, 2'h0, 7'h2E}, {2'h0, 2'h0, 7'h2F}};
	logic [6:0]  bad [3] = '{7'h2A, 7'h00, 7'h78};

	i2c_master_model master (.scl(scl), .sda_drv(sda_drv), .sda(sda));

	pot_i2c_cmd #(.PROG_CYCLES(200)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_addr_pin_low(pin_lo), .slave_addr_pin_high(pin_hi),
		.pot_reset_n(pot_reset_n), .wiper_tap_ch1(w1), .wiper_tap_ch2(w2), .shutdown_ch(shutdown_ch),
		.nvm_busy(nvm_busy));

	// Seven-bit variant strapped to a fixed address on the same wires, so the ignored data bit shows.
	pot_i2c_cmd #(.PROG_CYCLES(200), .RES_7BIT(1'b1)) uut7 (.hclk(hclk), .hresetn(hresetn), .hsel(1'b0),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(), .hreadyout(), .hresp(), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n7),
		.slave_addr_pin_low(2'h0), .slave_addr_pin_high(2'h0), .pot_reset_n(pot_reset_n),
		.wiper_tap_ch1(w7), .wiper_tap_ch2(), .shutdown_ch(), .nvm_busy());

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk_reg(input logic [7:0] ad, input logic [31:0] exp);
		ahb(1'b0, ad, 32'h0);
		`CHK({hresp, rd}, {1'b0, exp})
	endtask

	// Sends one command word; a refused address ends the frame at once.
	task automatic cmd(input logic [15:0] w, input logic exp_ack);
		logic ok;
		master.start;
		master.wbyte({dev, 1'b0}, ok);
		if (ok) begin
			master.wbyte(w[15:8], a);
			ok = ok & a;
			master.wbyte(w[7:0], a);
			ok = ok & a;
		end
		master.stop;
		`CHK(ok, exp_ack)
		repeat (4) @(posedge hclk);
	endtask

	task automatic rdb(input logic [15:0] sel, input logic [7:0] exp);
		cmd(sel, 1'b1);
		master.start;
		master.wbyte({dev, 1'b1}, a);
		master.rbyte(1'b1, b);
		master.stop;
		`CHK({a, b}, {1'b1, exp})
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 400 && nvm_busy !== 1'b0; i++) @(posedge hclk);
		`CHK(nvm_busy, 1'b0)
	endtask

	task automatic give_verdict;
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	initial begin
		repeat (40000) @(posedge hclk);
		err_count++;
		give_verdict;
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{pot_reset_n, pin_lo, pin_hi, dev, err_count, checks_done} = {1'b1, 4'h0, 7'h2F, 64'h0};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		`CHK({w1, w2, shutdown_ch, nvm_busy}, {NV_RESET, NV_RESET, 3'h0})
		repeat (620) @(posedge hclk);
		`CHK({w1, w2}, {NV_RESET, NV_RESET})
		for (int i = 0; i < 9; i++) begin
			{pin_lo, pin_hi} <= straps[i][10:7];
			repeat (4) @(posedge hclk);
			chk_reg(REG_SLAVE, {25'h0, straps[i][6:0]});
		end
		{pin_lo, pin_hi} <= {PIN_OPEN, PIN_OPEN};
		ahb(1'b1, REG_CTRL, 32'h1);
		chk_reg(REG_CTRL, 32'h1);
		chk_reg(REG_SLAVE, 32'h20);
		for (int i = 0; i < 3; i++) begin
			dev = bad[i];
			cmd(16'h1012, 1'b0);
		end
		dev = 7'h2F;
		cmd(16'h1037, 1'b1);
		`CHK(w7, 8'h36)
		rdb(16'h3003, 8'h36);
		dev = 7'h20;
		`CHK(w1, NV_RESET)
		cmd(16'h1037, 1'b1);
		`CHK(w1, 8'h37)
		cmd(16'h2155, 1'b1);
		`CHK(w2, NV_RESET)
		cmd(16'h0155, 1'b1);
		cmd(16'hF1AA, 1'b1);
		`CHK({w1, w2, shutdown_ch}, {8'h37, NV_RESET, 2'h0})
		cmd(16'h6800, 1'b1);
		`CHK({w1, w2}, {8'h37, 8'h55})
		rdb(16'h3003, 8'h37);
		rdb(16'h3001, NV_RESET);
		rdb(16'h3100, 8'h55);
		cmd(16'h8044, 1'b1);
		`CHK(nvm_busy, 1'b1)
		cmd(16'h1011, 1'b0);
		wait_idle;
		`CHK(w1, 8'h37)
		chk_reg(REG_NV, 32'h8044);
		cmd(16'h7000, 1'b1);
		`CHK(w1, 8'h44)
		cmd(16'h7101, 1'b1);
		wait_idle;
		chk_reg(REG_NV, 32'h5544);
		cmd(16'hC801, 1'b1);
		`CHK(shutdown_ch, 2'h3)
		cmd(16'hC000, 1'b1);
		cmd(16'h1166, 1'b1);
		`CHK({shutdown_ch, w1, w2}, {2'h2, 8'h44, 8'h66})
		cmd(16'h8233, 1'b1);
		wait_idle;
		chk_reg(REG_NV, 32'h3344);
		cmd(16'hB000, 1'b1);
		repeat (620) @(posedge hclk);
		`CHK({w1, w2}, {8'h44, 8'h33})
		cmd(16'h1899, 1'b1);
		`CHK({w1, w2}, {8'h99, 8'h99})
		pot_reset_n <= 1'b0;
		repeat (20) @(posedge hclk);
		pot_reset_n <= 1'b1;
		repeat (630) @(posedge hclk);
		`CHK({w1, w2}, {8'h44, 8'h33})
		chk_reg(REG_STATUS, 32'h0004_3344);
		chk_reg(8'h10, 32'h0);
		give_verdict;
	end
endmodule
